// >>> shared/flr_pkg.sv
`default_nettype none
package flr_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_THRESH   = 8'h04;
  localparam logic [7:0] ADR_STATUS   = 8'h08;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h10;

  localparam int unsigned CTRL_FB2M_BIT = 0;
  localparam int unsigned THR_CRIT_LSB  = 0;
  localparam int unsigned THR_GOOD_LSB  = 8;
  localparam int unsigned THR_VGOOD_LSB = 16;
  localparam logic [7:0]  THR_CRIT_RST  = 8'h40;
  localparam logic [7:0]  THR_GOOD_RST  = 8'h80;
  localparam logic [7:0]  THR_VGOOD_RST = 8'hC0;

  localparam int unsigned ST_DIP_LSB   = 0;
  localparam int unsigned ST_QA_LSB    = 4;
  localparam int unsigned ST_QB_LSB    = 6;
  localparam int unsigned ST_ACTB_BIT  = 8;
  localparam int unsigned ST_CONF_BIT  = 9;
  localparam int unsigned ST_RELAY_BIT = 10;

  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned IRQ_QA       = 0;
  localparam int unsigned IRQ_QB       = 1;
  localparam int unsigned IRQ_FAILOVER = 2;
  localparam int unsigned IRQ_CONFLICT = 3;

  // Cycles the switch synchroniser needs before the power-up sample.
  localparam logic [1:0] CFG_SETTLE = 2'h3;

  // Data pins start at their idle level, or reset would send a false start bit.
  localparam logic [8:0] PIN_SYNC_RST = 9'h00F;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {Q_ERR, Q_CRIT, Q_GOOD, Q_VGOOD} flr_qual_t;

  typedef struct packed {
    logic b_off;
    logic redund;
    logic idle_light_off;
    logic star;
  } flr_cfg_t;

  typedef struct packed {
    logic red;
    logic yellow;
    logic green_lo;
    logic green_hi;
  } flr_bar_t;

  localparam flr_bar_t BAR_VGOOD = 4'h7;
  localparam flr_bar_t BAR_GOOD  = 4'h6;
  localparam flr_bar_t BAR_CRIT  = 4'h4;
  localparam flr_bar_t BAR_ERR   = 4'h8;
  localparam flr_bar_t BAR_OFF   = 4'h0;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } flr_wb_req_t;

endpackage
`default_nettype wire

// >>> verilog/flr_route_diag.sv
// Local design decisions: the placing of the registers and the Wishbone slave port.
`default_nettype none
// Notes on behaviour
// - Switch 2 sets idle light polarity.
// - Dark idle suppresses power diagnostics on bar.
// - Four power levels, each own bar pattern.
// - Reserve reached opens alarm relay, data flows.
// - Switch 1 off: copper to optical only.
// - Switch 1 on: copper, optical, backplane interconnected.
// - All switches off by default.
// - Switches latched once at power-up only.
// - Failover moves A to B at critical.
// - Switch 4 disables B; unused B shows an unlit bar.
// - Fieldbus failover with B disabled is rejected.
// - Dark idle bar just follows received light.
// - Relay opens on supply fail, or on fibre break with bright idle.
module flr_route_diag
  import flr_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire flr_pkg::flr_wb_req_t  wb_req_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [3:0]            dip_i,
  input  wire logic                  supply_ok_i,
  input  wire logic                  cu_rx_i,
  input  wire logic                  bp_rx_i,
  input  wire logic                  fo_rx_a_i,
  input  wire logic                  fo_rx_b_i,
  input  wire logic [7:0]            rx_pwr_a_i,
  input  wire logic [7:0]            rx_pwr_b_i,
  output logic                       cu_tx_o,
  output logic                       bp_tx_o,
  output logic                       bp_tx_oe_o,
  output logic                       fo_tx_a_o,
  output logic                       fo_tx_b_o,
  output flr_pkg::flr_bar_t          bar_a_o,
  output flr_pkg::flr_bar_t          bar_b_o,
  output logic                       relay_o,
  output logic                       irq_o
);
  import flr_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [8:0] pin_meta;
  logic [8:0] pin_sync;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pin_meta <= PIN_SYNC_RST;
      pin_sync <= PIN_SYNC_RST;
    end
    else if (ce_i)
    begin
      pin_meta <= {dip_i, supply_ok_i, bp_rx_i, cu_rx_i, fo_rx_b_i, fo_rx_a_i};
      pin_sync <= pin_meta;
    end
  end

  logic       ra_light;
  logic       rb_light;
  logic       cu_rx;
  logic       bp_rx;
  logic       supply_ok;
  logic [3:0] dip_s;
  assign {dip_s, supply_ok, bp_rx, cu_rx, rb_light, ra_light} = pin_sync;

  // ------------------------------------------------------------
  // Power-up configuration
  // ------------------------------------------------------------
  flr_cfg_t   cfg;
  logic       cfg_done;
  logic [1:0] cfg_cnt;

  // Sampled once after reset; the switches are not meant to move under power.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      cfg      <= '0;
      cfg_done <= 1'b0;
      cfg_cnt  <= 2'h0;
    end
    else if (ce_i && !cfg_done)
    begin
      cfg_cnt <= cfg_cnt + 2'h1;
      if (cfg_cnt == CFG_SETTLE)
      begin
        cfg      <= dip_s;
        cfg_done <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic             fb2m;
  logic [7:0]       thr_crit;
  logic [7:0]       thr_good;
  logic [7:0]       thr_vgood;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic             wr_fire;
  logic             rd_go;

  assign wr_fire = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_ack_o;
  assign rd_go   = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      fb2m      <= 1'b0;
      thr_crit  <= THR_CRIT_RST;
      thr_good  <= THR_GOOD_RST;
      thr_vgood <= THR_VGOOD_RST;
      irq_mask  <= '0;
    end
    else if (ce_i && wr_fire)
    begin
      if (wb_req_i.adr == ADR_CTRL && wb_req_i.sel[0])
      begin
        fb2m <= wb_req_i.dat[CTRL_FB2M_BIT];
      end
      if (wb_req_i.adr == ADR_THRESH)
      begin
        if (wb_req_i.sel[0])
        begin
          thr_crit <= wb_req_i.dat[THR_CRIT_LSB +: 8];
        end
        if (wb_req_i.sel[1])
        begin
          thr_good <= wb_req_i.dat[THR_GOOD_LSB +: 8];
        end
        if (wb_req_i.sel[2])
        begin
          thr_vgood <= wb_req_i.dat[THR_VGOOD_LSB +: 8];
        end
      end
      if (wb_req_i.adr == ADR_IRQ_MASK && wb_req_i.sel[0])
      begin
        irq_mask <= wb_req_i.dat[IRQ_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Quality classification
  // ------------------------------------------------------------
  function automatic flr_qual_t classify(input logic [7:0] pwr, input logic [7:0] tc,
                                         input logic [7:0] tg, input logic [7:0] tv);
    flr_qual_t q;
    q = Q_ERR;
    if (pwr >= tv)
    begin
      q = Q_VGOOD;
    end
    else if (pwr >= tg)
    begin
      q = Q_GOOD;
    end
    else if (pwr >= tc)
    begin
      q = Q_CRIT;
    end
    return q;
  endfunction

  function automatic flr_bar_t bar_of(input flr_qual_t q, input logic dark, input logic light);
    flr_bar_t b;
    b = BAR_ERR;
    if (dark)
    begin
      b = light ? BAR_VGOOD : BAR_OFF;
    end
    else
    begin
      unique case (q)
        Q_VGOOD: b = BAR_VGOOD;
        Q_GOOD:  b = BAR_GOOD;
        Q_CRIT:  b = BAR_CRIT;
        Q_ERR:   b = BAR_ERR;
      endcase
    end
    return b;
  endfunction

  flr_qual_t qual_a;
  flr_qual_t qual_b;
  flr_qual_t qual_a_q;
  flr_qual_t qual_b_q;
  assign qual_a = classify(rx_pwr_a_i, thr_crit, thr_good, thr_vgood);
  assign qual_b = classify(rx_pwr_b_i, thr_crit, thr_good, thr_vgood);

  // ------------------------------------------------------------
  // Port selection and failover
  // ------------------------------------------------------------
  logic conflict;
  logic port_b_off;
  logic active_b;
  logic next_active_b;

  // Disabling B under fieldbus failover would reset the bus, so B stays on.
  assign conflict   = cfg.b_off && cfg.redund && fb2m;
  assign port_b_off = cfg.b_off && !conflict;

  always_comb
  begin
    next_active_b = active_b;
    if (!cfg.redund || port_b_off)
    begin
      next_active_b = 1'b0;
    end
    else if (!active_b && qual_a <= Q_CRIT)
    begin
      next_active_b = 1'b1;
    end
    else if (active_b && qual_a >= Q_GOOD)
    begin
      next_active_b = 1'b0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      active_b <= 1'b0;
    end
    else if (ce_i)
    begin
      active_b <= next_active_b;
    end
  end

  // ------------------------------------------------------------
  // Data routing
  // ------------------------------------------------------------
  logic ra_bit;
  logic rb_bit;
  logic opt_rx;
  logic fo_data;

  // Logic 1 is the idle level everywhere, so merging paths is an AND.
  assign ra_bit  = cfg.idle_light_off ? !ra_light : ra_light;
  assign rb_bit  = cfg.idle_light_off ? !rb_light : rb_light;
  assign opt_rx  = cfg.redund ? (active_b ? rb_bit : ra_bit) : (ra_bit && (port_b_off || rb_bit));
  assign fo_data = cfg.star ? (cu_rx && bp_rx) : cu_rx;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      cu_tx_o    <= 1'b1;
      bp_tx_o    <= 1'b1;
      bp_tx_oe_o <= 1'b0;
      fo_tx_a_o  <= 1'b1;
      fo_tx_b_o  <= 1'b1;
    end
    else if (ce_i)
    begin
      cu_tx_o    <= cfg.star ? (opt_rx && bp_rx) : opt_rx;
      bp_tx_o    <= cfg.star ? (opt_rx && cu_rx) : 1'b1;
      bp_tx_oe_o <= cfg.star;
      fo_tx_a_o  <= cfg.idle_light_off ? !fo_data : fo_data;
      fo_tx_b_o  <= port_b_off ? 1'b0 : (cfg.idle_light_off ? !fo_data : fo_data);
    end
  end

  // ------------------------------------------------------------
  // Display and alarm relay
  // ------------------------------------------------------------
  flr_qual_t qual_act;
  logic      path_ok;

  always_comb
  begin
    qual_act = qual_a;
    if (cfg.redund && active_b)
    begin
      qual_act = qual_b;
    end
    else if (!cfg.redund && !port_b_off && qual_b < qual_a)
    begin
      qual_act = qual_b;
    end
  end

  // Without steady idle light the power cannot be judged, so only supply counts.
  assign path_ok = cfg.idle_light_off || qual_act > Q_CRIT;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      bar_a_o <= BAR_OFF;
      bar_b_o <= BAR_OFF;
      relay_o <= 1'b0;
    end
    else if (ce_i)
    begin
      bar_a_o <= bar_of(qual_a, cfg.idle_light_off, ra_light);
      bar_b_o <= port_b_off ? BAR_OFF : bar_of(qual_b, cfg.idle_light_off, rb_light);
      relay_o <= supply_ok && path_ok && cfg_done;
    end
  end

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  logic             conf_seen;

  always_comb
  begin
    irq_evt               = '0;
    irq_evt[IRQ_QA]       = qual_a <= Q_CRIT && qual_a_q > Q_CRIT;
    irq_evt[IRQ_QB]       = !port_b_off && qual_b <= Q_CRIT && qual_b_q > Q_CRIT;
    irq_evt[IRQ_FAILOVER] = next_active_b && !active_b;
    irq_evt[IRQ_CONFLICT] = conflict && !conf_seen;
  end

  assign irq_clr = (wr_fire && wb_req_i.adr == ADR_IRQ_STAT && wb_req_i.sel[0])
                   ? wb_req_i.dat[IRQ_W-1:0] : '0;

  // A new event outweighs a clear arriving in the same cycle.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      irq_stat  <= '0;
      qual_a_q  <= Q_VGOOD;
      qual_b_q  <= Q_VGOOD;
      conf_seen <= 1'b0;
      irq_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_stat  <= (irq_stat & ~irq_clr) | irq_evt;
      qual_a_q  <= qual_a;
      qual_b_q  <= qual_b;
      conf_seen <= conflict;
      irq_o     <= |(((irq_stat & ~irq_clr) | irq_evt) & irq_mask);
    end
  end

  // ------------------------------------------------------------
  // Bus answer
  // ------------------------------------------------------------
  logic [31:0] rd_data;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (wb_req_i.adr)
      ADR_CTRL:
        rd_data[CTRL_FB2M_BIT] = fb2m;
      ADR_THRESH:
        rd_data = {8'h00, thr_vgood, thr_good, thr_crit};
      ADR_STATUS:
      begin
        rd_data[ST_DIP_LSB +: 4] = cfg;
        rd_data[ST_QA_LSB +: 2]  = qual_a;
        rd_data[ST_QB_LSB +: 2]  = qual_b;
        rd_data[ST_ACTB_BIT]     = active_b;
        rd_data[ST_CONF_BIT]     = conflict;
        rd_data[ST_RELAY_BIT]    = relay_o;
      end
      ADR_IRQ_STAT:
        rd_data[IRQ_W-1:0] = irq_stat;
      ADR_IRQ_MASK:
        rd_data[IRQ_W-1:0] = irq_mask;
      default:
        rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= rd_go;
      wb_dat_o <= rd_go ? rd_data : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i || !ce_i);

  idle_polarity_a: assert property (
    cfg_done && ce_i |=> fo_tx_a_o == (cfg.idle_light_off ^ $past(fo_data)))
    else $error("Port A light does not follow idle polarity.");

  dark_bar_a: assert property (
    cfg.idle_light_off |=> !bar_a_o.red && (bar_a_o == BAR_OFF) == !$past(ra_light))
    else $error("Bar shows diagnostics with dark idle.");

  crit_pattern_a: assert property (
    !cfg.idle_light_off && qual_a == Q_CRIT |=> bar_a_o == BAR_CRIT)
    else $error("Critical level shows the wrong bar.");

  relay_opens_a: assert property (
    !cfg.idle_light_off && qual_act <= Q_CRIT |=> !relay_o)
    else $error("Relay held closed at reserve level.");

  line_bus_off_a: assert property (
    cfg_done && !cfg.star |=> !bp_tx_oe_o && cu_tx_o == $past(opt_rx))
    else $error("Backplane driven in line mode.");

  star_bus_on_a: assert property (
    cfg.star |=> bp_tx_oe_o && bp_tx_o == $past(opt_rx && cu_rx))
    else $error("Backplane not joined in star mode.");

  default_cfg_a: assert property (
    !cfg_done |-> cfg == '0)
    else $error("Configuration not at default before sampling.");

  cfg_frozen_a: assert property (
    cfg_done |=> $stable(cfg) && cfg_done)
    else $error("Switch settings changed after power-up.");

  failover_b_a: assert property (
    cfg.redund && !port_b_off && !active_b && qual_a <= Q_CRIT |=> active_b)
    else $error("Failover to port B missed.");

  port_b_off_a: assert property (
    port_b_off |=> bar_b_o == BAR_OFF && !fo_tx_b_o)
    else $error("Disabled port B still active.");

  fieldbus_guard_a: assert property (
    cfg.b_off && cfg.redund && fb2m |=> fo_tx_b_o == fo_tx_a_o)
    else $error("Port B disabled under fieldbus failover.");

  supply_fail_a: assert property (
    !supply_ok |=> !relay_o)
    else $error("Relay closed without supply.");

endmodule
`default_nettype wire

// >>> dv/flr_far_model.sv
`default_nettype none
module flr_far_model (
  input  wire logic       clock_i,
  input  wire logic       bit_i,
  input  wire logic       dark_idle_i,
  input  wire logic       b_cut_i,
  input  wire logic [7:0] pwr_a_i,
  input  wire logic [7:0] pwr_b_i,
  output var  logic       light_a_o,
  output var  logic       light_b_o,
  output var  logic [7:0] pwr_a_o,
  output var  logic [7:0] pwr_b_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------
  // Remote converter transmitter
  // ----------------------------------------------------------
  // A cut fibre carries neither light nor power, so port B reads as broken.
  always_ff @(posedge clock_i)
  begin
    light_a_o <= bit_i ^ dark_idle_i;
    light_b_o <= b_cut_i ? 1'b0 : bit_i ^ dark_idle_i;
    pwr_a_o   <= pwr_a_i;
    pwr_b_o   <= b_cut_i ? 8'h00 : pwr_b_i;
  end
endmodule
`default_nettype wire

// >>> dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flr_pkg::*;

  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic        sup_ok  = 1'b1;
  logic [3:0]  dip     = 4'h0;
  logic        cu_rx   = 1'b1;
  logic        bp_rx   = 1'b1;
  logic        tx_bit  = 1'b1;
  logic        pol     = 1'b0;
  logic        b_cut   = 1'b0;
  logic [7:0]  pa      = 8'hFF;
  logic [7:0]  pb      = 8'hFF;
  flr_wb_req_t wb_req  = '0;
  logic [31:0] wb_dat;
  logic [31:0] rdat;
  logic        wb_ack, cu_tx, bp_tx, bp_oe, fo_a, fo_b, relay, irq, lt_a, lt_b;
  flr_bar_t    bar_a, bar_b;
  logic [7:0]  pwr_a, pwr_b;
  int          err_count   = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  logic [7:0]  pw [5]   = '{8'h3F, 8'h40, 8'h7F, 8'h80, 8'hC0};
  flr_bar_t    bars [5] = '{BAR_ERR, BAR_CRIT, BAR_CRIT, BAR_GOOD, BAR_VGOOD};
  flr_qual_t   qs [5]   = '{Q_ERR, Q_CRIT, Q_CRIT, Q_GOOD, Q_VGOOD};

  always #2.5 clock_i = ~clock_i;

  flr_route_diag uut (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .wb_req_i(wb_req),
    .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .dip_i(dip), .supply_ok_i(sup_ok),
    .cu_rx_i(cu_rx), .bp_rx_i(bp_rx), .fo_rx_a_i(lt_a), .fo_rx_b_i(lt_b),
    .rx_pwr_a_i(pwr_a), .rx_pwr_b_i(pwr_b), .cu_tx_o(cu_tx), .bp_tx_o(bp_tx),
    .bp_tx_oe_o(bp_oe), .fo_tx_a_o(fo_a), .fo_tx_b_o(fo_b), .bar_a_o(bar_a),
    .bar_b_o(bar_b), .relay_o(relay), .irq_o(irq));

  flr_far_model far (
    .clock_i(clock_i), .bit_i(tx_bit), .dark_idle_i(pol), .b_cut_i(b_cut),
    .pwr_a_i(pa), .pwr_b_i(pb), .light_a_o(lt_a), .light_b_o(lt_b),
    .pwr_a_o(pwr_a), .pwr_b_o(pwr_b));

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // The whole run needs under 3000 cycles; a hang is stopped at 8000 cycles.
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
    @(posedge clock_i);
    while (wb_ack !== 1'b1)
      @(posedge clock_i);
    rdat = wb_dat;
    wb_req <= '0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, rdat & m, e);
  endtask

  // Switch outputs settle through two sync stages, a register and the model.
  task automatic settle;
    repeat (6) @(posedge clock_i);
    #1;
  endtask

  task automatic pwr_up(input logic [3:0] d);
    @(posedge clock_i);
    rst_i <= 1'b1;
    dip   <= d;
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    settle();
    wb(1'b1, ADR_IRQ_STAT, 32'h0000000F);
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  initial
  begin
    pwr_up(4'h0);
    rchk("status", ADR_STATUS, 32'h7FF, 32'h4F0);
    rchk("thresh", ADR_THRESH, 32'hFFFFFFFF, 32'hC08040);
    rchk("ctrl", ADR_CTRL, 32'hFFFFFFFF, 32'h0);
    rchk("irq_stat", ADR_IRQ_STAT, 32'hF, 32'h0);
    rchk("unmapped", 8'h14, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock_i);
      cu_rx  <= i[0];
      tx_bit <= i[1];
      bp_rx  <= i[0] ^ i[1];
      settle();
      chk("fo_a", fo_a, i[0]);
      chk("fo_b", fo_b, i[0]);
      chk("cu_tx", cu_tx, i[1]);
      chk("bp_tx", {bp_oe, bp_tx}, 2'b01);
    end
    wb(1'b1, ADR_IRQ_MASK, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clock_i);
      pa <= pw[i];
      settle();
      chk("bar_a", bar_a, bars[i]);
      chk("relay", relay, i > 2);
      rchk("qual_a", ADR_STATUS, 32'h30, {qs[i], 4'h0});
    end
    chk("irq_hold", irq, 1'b1);
    wb(1'b1, ADR_IRQ_STAT, 32'h1);
    settle();
    chk("irq_clr", irq, 1'b0);
    wb(1'b1, ADR_IRQ_MASK, 32'h0);
    pa <= 8'h40;
    settle();
    chk("irq_masked", irq, 1'b0);
    rchk("irq_stat", ADR_IRQ_STAT, 32'h1, 32'h1);
    wb(1'b1, ADR_IRQ_MASK, 32'h1);
    settle();
    chk("irq_unmask", irq, 1'b1);
    wb(1'b1, ADR_IRQ_STAT, 32'h1);
    pa    <= 8'hFF;
    b_cut <= 1'b1;
    settle();
    chk("bar_b_red", bar_b, BAR_ERR);
    chk("relay_cut", relay, 1'b0);
    rchk("irq_b", ADR_IRQ_STAT, 32'h2, 32'h2);
    @(posedge clock_i);
    b_cut  <= 1'b0;
    sup_ok <= 1'b0;
    settle();
    chk("relay_sup", relay, 1'b0);
    @(posedge clock_i);
    sup_ok <= 1'b1;
    dip    <= 4'hF;
    settle();
    chk("relay_back", relay, 1'b1);
    rchk("cfg_held", ADR_STATUS, 32'hF, 32'h0);
    pwr_up(4'h3);
    pol <= 1'b1;
    pa  <= 8'h3F;
    rchk("cfg", ADR_STATUS, 32'hF, 32'h3);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock_i);
      cu_rx  <= i[0];
      bp_rx  <= i[1];
      tx_bit <= i[2];
      settle();
      chk("cu_tx", cu_tx, i[1] & i[2]);
      chk("bp_tx", {bp_oe, bp_tx}, {1'b1, i[0] & i[2]});
      chk("fo_a", fo_a, !(i[0] & i[1]));
      chk("bar_dark", bar_a, i[2] ? BAR_OFF : BAR_VGOOD);
    end
    chk("relay_dark", relay, 1'b1);
    @(posedge clock_i);
    pol <= 1'b0;
    pa  <= 8'hFF;
    pwr_up(4'h4);
    wb(1'b1, ADR_IRQ_MASK, 32'h4);
    rchk("on_a", ADR_STATUS, 32'h100, 32'h0);
    pa <= 8'h40;
    settle();
    rchk("fail_b", ADR_STATUS, 32'h100, 32'h100);
    chk("relay_b", relay, 1'b1);
    chk("irq_fail", irq, 1'b1);
    pa <= 8'h80;
    settle();
    rchk("back_a", ADR_STATUS, 32'h100, 32'h0);
    pwr_up(4'h8);
    b_cut <= 1'b1;
    settle();
    chk("fo_b_off", fo_b, 1'b0);
    chk("bar_b_off", bar_b, BAR_OFF);
    chk("relay_boff", relay, 1'b1);
    @(posedge clock_i);
    b_cut <= 1'b0;
    pwr_up(4'hC);
    rchk("conf_off", ADR_STATUS, 32'h200, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h1);
    settle();
    rchk("conf_on", ADR_STATUS, 32'h200, 32'h200);
    rchk("conf_irq", ADR_IRQ_STAT, 32'h8, 32'h8);
    chk("fo_b_kept", fo_b, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
